// ### flash_cmd_map.vh
// constants for the flash command sequencer
// Operation
// [RL1] a command register write clears the ready flag until the command ends
// [RL2] completion sets ready and raises the interrupt when its enable is one
// [RL3] every command but quick page read raises a completion interrupt
// [RL4] high speed bus reads of flash stall while a command runs
// [RL5] a written command starts only on an idle high speed bus cycle
// [RL6] masters leave idle cycles on the high speed bus after a command
// [RL7] software waits for completion before reading flash or loading buffer
// [RL8] wrong key or invalid code changes nothing and sets programming error
// [RL9] a command written while busy changes nothing, sets programming error
// [RL10] writing or erasing a locked or boot protected page sets lock error
// [RL11] a non-secure master programming a secure page sets lock error
// [RL12] page write copies the buffer to the page in the page number field
// [RL13] software writes the page buffer with aligned whole words only
// [RL14] single word updates clear buffer, load AND of old and new, then write
// [RL15] erase all clears array, fuse bits and security bit, not user page
// [RL16] erase all wipes volatile memories before erasing the security bit
// [RL17] erase all runs only with no region locked and zero boot protection
// [RL18] a lock error raises the interrupt when its enable is one
// [RL19] sixteen equal lock regions each refuse writes and erases when locked
// [RL20] lock and unlock commands act on the region holding the given page
// [RL21] lock bits are the lowest 16 fuse bits, erased one means unlocked
// [RL22] buffer writes only clear bits; only clear buffer sets them again
// [RL23] one interrupt line ORs ready and lock error, each with its enable
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// command word layout
`define FC_KEY_HI      31
`define FC_KEY_LO      24
`define FC_PAGE_HI     23
`define FC_PAGE_LO     8
`define FC_CODE_HI     5
`define FC_CODE_LO     0
`define FC_KEY_VALUE   8'hA5

// command codes
`define FC_OP_NOP      6'h00
`define FC_OP_WP       6'h01
`define FC_OP_EP       6'h02
`define FC_OP_CPB      6'h03
`define FC_OP_LP       6'h04
`define FC_OP_UP       6'h05
`define FC_OP_EA       6'h06
`define FC_OP_WGPB     6'h07
`define FC_OP_EGPB     6'h08
`define FC_OP_QPR      6'h0C

// fuse layout and reset values
`define FC_BOOT_HI     19
`define FC_BOOT_LO     17
`define FC_BOOT_NONE   3'h7
`define FC_FUSE_INIT   32'hFFFFFFFF
`define FC_LOCK_BITS   16

// timing: cycles an erase or fuse step takes in the flash macro
`define FC_OP_CYCLES   16

`endif

// ### flash_command_sequencer.v
// command sequencer of the on-chip flash controller
`timescale 1ns/1ps
`include "flash_cmd_map.vh"

module flash_command_sequencer #(
    parameter PAGE_W       = 10,  // page number width
    parameter PBW          = 7,   // log2 of words in the page buffer
    parameter SECURE_PAGES = 0,   // pages below this need a secure master
    parameter OP_CYCLES    = `FC_OP_CYCLES
) (
    input  wire                  mclk_i,
    input  wire                  rst_i,
    input  wire                  cmd_wr_i,
    input  wire [31:0]           cmd_wdata_i,
    input  wire                  cmd_secure_i,
    input  wire                  sts_rd_i,
    input  wire                  rdy_ie_i,
    input  wire                  lock_ie_i,
    input  wire                  pb_wr_i,
    input  wire [PAGE_W+PBW-1:0] pb_addr_i,
    input  wire [31:0]           pb_wdata_i,
    input  wire                  hsb_idle_i,
    output wire                  ready_flag_o,
    output wire                  programming_error_flag_o,
    output wire                  lock_error_flag_o,
    output wire                  irq_o,
    output wire                  hsb_stall_o,
    output wire [PAGE_W-1:0]     page_number_field_o,
    output wire [31:0]           fuse_o,
    output wire                  security_bit_o,
    output wire                  fl_wr_o,
    output wire [PAGE_W+PBW-1:0] fl_addr_o,
    output wire [31:0]           fl_wdata_o,
    output wire                  fl_erase_page_o,
    output wire                  fl_erase_all_o,
    output wire                  wipe_volatile_o
);

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_WAIT  = 3'h1;
    localparam [2:0] S_RUN   = 3'h2;
    localparam [2:0] S_PROG  = 3'h3;
    localparam [2:0] S_WIPE  = 3'h4;
    localparam [2:0] S_ERASE = 3'h5;
    localparam        PB_N   = 1 << PBW;
    // integer sums cut on purpose to the counter widths
    localparam [31:0] RUN_LAST_W = OP_CYCLES - 1;
    localparam [31:0] PB_LAST_W  = PB_N - 1;
    localparam [15:0] RUN_LAST = RUN_LAST_W[15:0];
    localparam [PBW-1:0] PB_LAST = PB_LAST_W[PBW-1:0];

    reg [31:0] pb_mem [0:PB_N-1];

    reg [2:0]        state_reg;
    reg [5:0]        op_reg;
    reg [PAGE_W-1:0] page_reg;
    reg              sec_reg;
    reg [15:0]       cnt_reg;
    reg [PBW-1:0]    widx_reg;
    reg              ready_reg;
    reg              perr_reg;
    reg              lerr_reg;
    reg              rdy_irq_ok_reg;
    reg              irq_reg;
    reg              stall_reg;
    reg [31:0]       fuse_reg;
    reg              secbit_reg;
    reg              pb_clr_reg;
    reg              fl_wr_reg;
    reg [PAGE_W+PBW-1:0] fl_addr_reg;
    reg [31:0]       fl_wdata_reg;
    reg              fl_ep_reg;
    reg              fl_ea_reg;
    reg              wipe_reg;

    // region of a page: top four page bits, giving 16 equal regions
    function [3:0] region_of;
        input [PAGE_W-1:0] pg;
        begin
            region_of = pg[PAGE_W-1 -: 4];
        end
    endfunction

    // boot area covers 2^(7-bp) pages; the all-ones code protects none
    function boot_hit;
        input [PAGE_W-1:0] pg;
        input [2:0]        bp;
        begin
            if (bp == `FC_BOOT_NONE)
                boot_hit = 1'b0;
            else
                boot_hit = ((pg >> (3'h7 - bp)) == {PAGE_W{1'b0}});
        end
    endfunction

    function code_valid;
        input [5:0] c;
        begin
            case (c)
                `FC_OP_NOP, `FC_OP_WP, `FC_OP_EP, `FC_OP_CPB,
                `FC_OP_LP, `FC_OP_UP, `FC_OP_EA, `FC_OP_WGPB,
                `FC_OP_EGPB, `FC_OP_QPR: code_valid = 1'b1;
                default: code_valid = 1'b0;
            endcase
        end
    endfunction

    // decode of the incoming command word
    wire [7:0]        in_key  = cmd_wdata_i[`FC_KEY_HI:`FC_KEY_LO];
    wire [5:0]        in_code = cmd_wdata_i[`FC_CODE_HI:`FC_CODE_LO];
    wire [15:0]       in_pfld = cmd_wdata_i[`FC_PAGE_HI:`FC_PAGE_LO];
    wire [PAGE_W-1:0] in_page = in_pfld[PAGE_W-1:0];
    wire              busy    = (state_reg != S_IDLE);
    wire              cmd_ok  = (in_key == `FC_KEY_VALUE) &&
                                code_valid(in_code);

    // protection checks on the latched command
    wire [2:0] boot_sz  = fuse_reg[`FC_BOOT_HI:`FC_BOOT_LO];
    wire       reg_lock = ~fuse_reg[region_of(page_reg)]; // [RL19] [RL21]
    wire       sec_need = (page_reg < SECURE_PAGES) && !sec_reg;
    wire       pg_bad   = reg_lock || boot_hit(page_reg, boot_sz) // [RL10]
                          || sec_need;                            // [RL11]
    wire       any_lock = (fuse_reg[`FC_LOCK_BITS-1:0] !=
                           {`FC_LOCK_BITS{1'b1}});
    wire       ea_bad   = any_lock || (boot_sz != `FC_BOOT_NONE); // [RL17]
    wire [4:0] fuse_ix  = page_reg[4:0];
    // fuses above the lock bits are frozen while the device is secured
    wire       fuse_bad = !secbit_reg && (fuse_ix >= 5'h10);
    wire       op_is_pg = (op_reg == `FC_OP_WP) || (op_reg == `FC_OP_EP);
    wire       op_is_fz = (op_reg == `FC_OP_WGPB) ||
                          (op_reg == `FC_OP_EGPB);
    wire       start_bad = (op_is_pg && pg_bad) ||
                           (op_reg == `FC_OP_EA && ea_bad) ||
                           (op_is_fz && fuse_bad);

    // page buffer: writes AND into the word, clear sets all ones
    integer i;
    always @(posedge mclk_i) begin
        if (pb_clr_reg) begin
            for (i = 0; i < PB_N; i = i + 1)
                pb_mem[i] <= {32{1'b1}};                          // [RL22]
        end else if (pb_wr_i) begin
            pb_mem[pb_addr_i[PBW-1:0]] <=
                pb_mem[pb_addr_i[PBW-1:0]] & pb_wdata_i;          // [RL22]
        end
    end

    // sequencer, flags and flash macro strobes
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg      <= S_IDLE;
            op_reg         <= `FC_OP_NOP;
            page_reg       <= {PAGE_W{1'b0}};
            sec_reg        <= 1'b0;
            cnt_reg        <= 16'h0000;
            widx_reg       <= {PBW{1'b0}};
            ready_reg      <= 1'b1;
            perr_reg       <= 1'b0;
            lerr_reg       <= 1'b0;
            rdy_irq_ok_reg <= 1'b0;
            stall_reg      <= 1'b0;
            fuse_reg       <= `FC_FUSE_INIT;
            secbit_reg     <= 1'b1;
            pb_clr_reg     <= 1'b0;
            fl_wr_reg      <= 1'b0;
            fl_addr_reg    <= {(PAGE_W+PBW){1'b0}};
            fl_wdata_reg   <= 32'h00000000;
            fl_ep_reg      <= 1'b0;
            fl_ea_reg      <= 1'b0;
            wipe_reg       <= 1'b0;
        end else begin
            fl_wr_reg  <= 1'b0;
            fl_ep_reg  <= 1'b0;
            fl_ea_reg  <= 1'b0;
            wipe_reg   <= 1'b0;
            pb_clr_reg <= 1'b0;

            // status read clears error flags; a same-cycle set wins below
            if (sts_rd_i) begin
                perr_reg <= 1'b0;                                 // [RL8]
                lerr_reg <= 1'b0;                                 // [RL10]
            end

            // buffer loads track the page they aim at
            if (pb_wr_i && !busy)
                page_reg <= pb_addr_i[PAGE_W+PBW-1:PBW];          // [RL12]

            if (cmd_wr_i) begin
                if (busy) begin
                    perr_reg <= 1'b1;                             // [RL9]
                end else if (!cmd_ok) begin
                    perr_reg <= 1'b1;                             // [RL8]
                end else begin
                    ready_reg      <= 1'b0;                       // [RL1]
                    rdy_irq_ok_reg <= 1'b0;
                    op_reg         <= in_code;
                    page_reg       <= in_page;                    // [RL12]
                    sec_reg        <= cmd_secure_i;
                    state_reg      <= S_WAIT;
                end
            end

            case (state_reg)
                S_WAIT: begin
                    // hold off until the fast bus shows an idle cycle
                    if (hsb_idle_i) begin                         // [RL5]
                        cnt_reg  <= 16'h0000;
                        widx_reg <= {PBW{1'b0}};
                        if (start_bad) begin
                            lerr_reg  <= 1'b1;       // [RL10] [RL17]
                            state_reg <= S_RUN;
                            cnt_reg   <= RUN_LAST;
                            op_reg    <= `FC_OP_NOP;
                        end else begin
                            stall_reg <= 1'b1;                    // [RL4]
                            case (op_reg)
                                `FC_OP_WP: state_reg <= S_PROG;
                                `FC_OP_EA: state_reg <= S_WIPE;
                                default:   state_reg <= S_RUN;
                            endcase
                            case (op_reg)
                                `FC_OP_EP: fl_ep_reg <= 1'b1;
                                `FC_OP_CPB: pb_clr_reg <= 1'b1;
                                `FC_OP_LP:                        // [RL20]
                                    fuse_reg[region_of(page_reg)] <= 1'b0;
                                `FC_OP_UP:                        // [RL20]
                                    fuse_reg[region_of(page_reg)] <= 1'b1;
                                `FC_OP_WGPB:                      // [RL21]
                                    fuse_reg[fuse_ix] <= 1'b0;
                                `FC_OP_EGPB:                      // [RL21]
                                    fuse_reg[fuse_ix] <= 1'b1;
                                default: ;
                            endcase
                        end
                    end
                end
                S_PROG: begin
                    // stream one buffer word per cycle into the page
                    fl_wr_reg    <= 1'b1;                         // [RL12]
                    fl_addr_reg  <= {page_reg, widx_reg};
                    fl_wdata_reg <= pb_mem[widx_reg];
                    widx_reg     <= widx_reg + {{(PBW-1){1'b0}}, 1'b1};
                    if (widx_reg == PB_LAST)
                        state_reg <= S_RUN;
                end
                S_WIPE: begin
                    // volatile wipe strictly ahead of the security erase
                    wipe_reg  <= 1'b1;                            // [RL16]
                    state_reg <= S_ERASE;
                end
                S_ERASE: begin
                    if (cnt_reg == 16'h0000)
                        fl_ea_reg <= 1'b1;                        // [RL15]
                    if (cnt_reg == RUN_LAST) begin
                        fuse_reg   <= `FC_FUSE_INIT;              // [RL15]
                        secbit_reg <= 1'b1;                       // [RL15]
                        state_reg  <= S_RUN;
                    end else begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                S_RUN: begin
                    if (cnt_reg >= RUN_LAST) begin
                        state_reg <= S_IDLE;
                        stall_reg <= 1'b0;                        // [RL4]
                        ready_reg <= 1'b1;                        // [RL2]
                        // quick page read completes without an interrupt
                        rdy_irq_ok_reg <= (op_reg != `FC_OP_QPR); // [RL3]
                    end else begin
                        cnt_reg <= cnt_reg + 16'h0001;
                    end
                end
                default: ;
            endcase
        end
    end

    // interrupt line from next-state flags so it tracks them exactly
    wire rdy_next = (state_reg == S_RUN && cnt_reg >= RUN_LAST) ? 1'b1 :
                    (cmd_wr_i && !busy && cmd_ok) ? 1'b0 : ready_reg;
    wire ok_next  = (state_reg == S_RUN && cnt_reg >= RUN_LAST) ?
                    (op_reg != `FC_OP_QPR) :                      // [RL3]
                    (cmd_wr_i && !busy && cmd_ok) ? 1'b0 : rdy_irq_ok_reg;
    wire le_next  = (state_reg == S_WAIT && hsb_idle_i && start_bad) ||
                    (lerr_reg && !sts_rd_i);

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= (rdy_next && ok_next && rdy_ie_i) ||       // [RL2]
                       (le_next && lock_ie_i);             // [RL18] [RL23]
    end

    assign ready_flag_o             = ready_reg;
    assign programming_error_flag_o = perr_reg;
    assign lock_error_flag_o        = lerr_reg;
    assign irq_o                    = irq_reg;
    assign hsb_stall_o              = stall_reg;
    assign page_number_field_o      = page_reg;
    assign fuse_o                   = fuse_reg;
    assign security_bit_o           = secbit_reg;
    assign fl_wr_o                  = fl_wr_reg;
    assign fl_addr_o                = fl_addr_reg;
    assign fl_wdata_o               = fl_wdata_reg;
    assign fl_erase_page_o          = fl_ep_reg;
    assign fl_erase_all_o           = fl_ea_reg;
    assign wipe_volatile_o          = wipe_reg;

endmodule // flash_command_sequencer

// ### flash_command_sequencer_bench.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module flash_command_sequencer_bench;
    reg         mclk_i = 1'b0, rst_i = 1'b1, cmd_wr_i = 1'b0;
    reg         cmd_secure_i = 1'b1, sts_rd_i = 1'b0, pb_wr_i = 1'b0;
    reg         rdy_ie_i = 1'b0, lock_ie_i = 1'b0;
    reg  [31:0] cmd_wdata_i = 32'h0, pb_wdata_i = 32'h0, w0 = 32'h0;
    reg  [16:0] pb_addr_i = 17'h0;
    wire        hsb_idle_i, ready_flag_o, programming_error_flag_o;
    wire        lock_error_flag_o, irq_o, hsb_stall_o, security_bit_o;
    wire        fl_wr_o, fl_erase_page_o, fl_erase_all_o, wipe_volatile_o;
    wire [9:0]  page_number_field_o;
    wire [31:0] fuse_o, fl_wdata_o;
    wire [16:0] fl_addr_o;
    integer     num_errors = 0, cmp_count = 0;
    integer     wr_cnt = 0, ep_cnt = 0, ea_cnt = 0, n0;
    flash_command_sequencer #(.SECURE_PAGES(8), .OP_CYCLES(2))
        flash_command_sequencer_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .cmd_wr_i(cmd_wr_i),
        .cmd_wdata_i(cmd_wdata_i), .cmd_secure_i(cmd_secure_i),
        .sts_rd_i(sts_rd_i), .rdy_ie_i(rdy_ie_i), .lock_ie_i(lock_ie_i),
        .pb_wr_i(pb_wr_i), .pb_addr_i(pb_addr_i), .pb_wdata_i(pb_wdata_i),
        .hsb_idle_i(hsb_idle_i), .ready_flag_o(ready_flag_o),
        .programming_error_flag_o(programming_error_flag_o),
        .lock_error_flag_o(lock_error_flag_o), .irq_o(irq_o),
        .hsb_stall_o(hsb_stall_o), .page_number_field_o(page_number_field_o),
        .fuse_o(fuse_o), .security_bit_o(security_bit_o), .fl_wr_o(fl_wr_o),
        .fl_addr_o(fl_addr_o), .fl_wdata_o(fl_wdata_o),
        .fl_erase_page_o(fl_erase_page_o), .fl_erase_all_o(fl_erase_all_o),
        .wipe_volatile_o(wipe_volatile_o));
    hsb_master_model #(.BURST(3)) hsb_master_model_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .stall_i(hsb_stall_o),
        .hsb_idle_o(hsb_idle_i));
    always #4 mclk_i = ~mclk_i;
    // tally flash-side strobes so a refused command can be told apart
    always @(posedge mclk_i) begin
        if (fl_wr_o === 1'b1) wr_cnt <= wr_cnt + 1;
        if (fl_erase_page_o === 1'b1) ep_cnt <= ep_cnt + 1;
        if (fl_erase_all_o === 1'b1) ea_cnt <= ea_cnt + 1;
        if (fl_wr_o === 1'b1 && fl_addr_o === {10'h007, 7'h00})
            w0 <= fl_wdata_o;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t ns: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    // one-cycle command write; the word is laid out key, page, code
    task send(input [7:0] k, input [5:0] c, input [9:0] p);
        begin
            @(posedge mclk_i);
            cmd_wr_i <= 1'b1;
            cmd_wdata_i <= {k, 6'h00, p, 2'h0, c};
            @(posedge mclk_i);
            cmd_wr_i <= 1'b0;
            #1;
        end
    endtask
    // software polls status before touching flash again
    task wait_rdy;
        integer n;
        begin
            n = 0;
            while (ready_flag_o !== 1'b1 && n < 500) begin
                @(posedge mclk_i);
                #1;
                n = n + 1;
            end
            chk(n < 500, 1);
        end
    endtask
    task cmd(input [5:0] c, input [9:0] p);
        begin
            send(`FC_KEY_VALUE, c, p);
            wait_rdy;
        end
    endtask
    task sts;
        begin
            @(posedge mclk_i);
            sts_rd_i <= 1'b1;
            @(posedge mclk_i);
            sts_rd_i <= 1'b0;
            #1;
        end
    endtask
    // whole aligned words only reach the page buffer
    task pbw(input [16:0] a, input [31:0] d);
        begin
            @(posedge mclk_i);
            pb_wr_i <= 1'b1;
            pb_addr_i <= a;
            pb_wdata_i <= d;
            @(posedge mclk_i);
            pb_wr_i <= 1'b0;
            #1;
        end
    endtask
    task t_reject;
        begin
            send(8'h5A, `FC_OP_EP, 10'h001);
            chk(programming_error_flag_o, 1);
            chk(ready_flag_o, 1);
            sts;
            chk(programming_error_flag_o, 0);
            send(`FC_KEY_VALUE, 6'h3F, 10'h001);
            chk(programming_error_flag_o, 1);
            sts;
            $display("test reject done");
        end
    endtask
    task t_erase;
        begin
            @(posedge mclk_i);
            rdy_ie_i <= 1'b1;
            n0 = ep_cnt;
            send(`FC_KEY_VALUE, `FC_OP_EP, 10'h005);
            chk(ready_flag_o, 0);
            send(`FC_KEY_VALUE, `FC_OP_EP, 10'h006);
            chk(programming_error_flag_o, 1);
            wait_rdy;
            chk(irq_o, 1);
            chk(ep_cnt - n0, 1);
            sts;
            $display("test erase done");
        end
    endtask
    task t_lock;
        begin
            @(posedge mclk_i);
            rdy_ie_i <= 1'b0;
            lock_ie_i <= 1'b1;
            cmd(`FC_OP_LP, 10'h3C0);
            chk(fuse_o[15:14], 2'h1);
            n0 = ep_cnt;
            cmd(`FC_OP_EP, 10'h3C5);
            chk(lock_error_flag_o, 1);
            chk(irq_o, 1);
            chk(ep_cnt - n0, 0);
            sts;
            cmd(`FC_OP_EA, 10'h000);
            chk(lock_error_flag_o, 1);
            chk(ea_cnt, 0);
            sts;
            cmd(`FC_OP_UP, 10'h3FF);
            chk(fuse_o[15], 1);
            cmd(`FC_OP_WGPB, 10'h011);
            cmd(`FC_OP_EP, 10'h001);
            chk(lock_error_flag_o, 1);
            chk(ep_cnt - n0, 0);
            sts;
            cmd(`FC_OP_EGPB, 10'h011);
            @(posedge mclk_i);
            cmd_secure_i <= 1'b0;
            n0 = wr_cnt;
            cmd(`FC_OP_WP, 10'h002);
            chk(lock_error_flag_o, 1);
            chk(wr_cnt - n0, 0);
            @(posedge mclk_i);
            cmd_secure_i <= 1'b1;
            lock_ie_i <= 1'b0;
            sts;
            $display("test lock done");
        end
    endtask
    task t_write;
        begin
            cmd(`FC_OP_CPB, 10'h000);
            pbw({10'h007, 7'h00}, 32'hF0F0F0F0);
            pbw({10'h007, 7'h00}, 32'h3C3C3C3C);
            chk(page_number_field_o, 10'h007);
            n0 = wr_cnt;
            cmd(`FC_OP_WP, 10'h007);
            chk(wr_cnt - n0, 128);
            chk(w0, 32'h30303030);
            @(posedge mclk_i);
            rdy_ie_i <= 1'b1;
            cmd(`FC_OP_QPR, 10'h007);
            chk(irq_o, 0);
            $display("test write done");
        end
    endtask
    task t_ea;
        begin
            cmd(`FC_OP_WGPB, 10'h014);
            chk(fuse_o[20], 0);
            cmd(`FC_OP_EA, 10'h000);
            chk(fuse_o, 32'hFFFFFFFF);
            chk(security_bit_o, 1);
            chk(ea_cnt, 1);
            $display("test erase all done");
        end
    endtask
    task close_out;
        begin
            $display("errors %0d compares %0d", num_errors, cmp_count);
            if (num_errors == 0 && cmp_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // main sequence after two cycles of reset
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reject;
        t_erase;
        t_lock;
        t_write;
        t_ea;
        close_out;
    end
    // the whole run needs a few hundred cycles; this cuts a hang short
    initial begin
        #100000;
        num_errors = num_errors + 1;
        close_out;
    end
endmodule // flash_command_sequencer_bench

// ### flash_sequencer_checker.sv
// assertion checker bound to the flash command sequencer ports
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module flash_sequencer_checker (
    input wire        mclk_i,
    input wire        rst_i,
    input wire        cmd_wr_i,
    input wire [31:0] cmd_wdata_i,
    input wire        rdy_ie_i,
    input wire        lock_ie_i,
    input wire        sts_rd_i,
    input wire        hsb_idle_i,
    input wire        ready_flag_o,
    input wire        programming_error_flag_o,
    input wire        lock_error_flag_o,
    input wire        irq_o,
    input wire        hsb_stall_o,
    input wire        fl_erase_all_o,
    input wire        wipe_volatile_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // decode of the written word; fuse commands left out as they may refuse
    wire [5:0] code = cmd_wdata_i[`FC_CODE_HI:`FC_CODE_LO];
    wire key_ok = cmd_wdata_i[`FC_KEY_HI:`FC_KEY_LO] == `FC_KEY_VALUE;
    wire good = key_ok && ((code >= 6'h01 && code <= 6'h06) ||
                           code == `FC_OP_QPR);
    reg  [5:0] last_code_reg;
    // remember the code of the last command written while ready, accepted or not
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            last_code_reg <= 6'h00;
        else if (cmd_wr_i && ready_flag_o)
            last_code_reg <= code;
    end
    sequence s_go;
        cmd_wr_i && good && ready_flag_o ##1 !ready_flag_o;
    endsequence
    sequence s_done;
        $rose(ready_flag_o) && last_code_reg != `FC_OP_QPR;
    endsequence
    property p_busy;
        cmd_wr_i && good && ready_flag_o |=> !ready_flag_o;
    endproperty
    property p_done;
        s_go |-> ##[1:400] ready_flag_o;
    endproperty
    property p_key;
        cmd_wr_i && !key_ok |=> programming_error_flag_o && ready_flag_o
            && !hsb_stall_o;
    endproperty
    property p_busy_wr;
        cmd_wr_i && !ready_flag_o |=> programming_error_flag_o;
    endproperty
    property p_start;
        $rose(hsb_stall_o) |-> $past(hsb_idle_i);
    endproperty
    property p_stall;
        hsb_stall_o |-> !ready_flag_o;
    endproperty
    property p_irq_rdy;
        s_done ##0 $past(rdy_ie_i) |-> irq_o;
    endproperty
    property p_qpr;
        $rose(ready_flag_o) && last_code_reg == `FC_OP_QPR &&
            !lock_error_flag_o |-> !irq_o;
    endproperty
    property p_lock_irq;
        lock_error_flag_o && $past(lock_ie_i) |-> irq_o;
    endproperty
    property p_wipe;
        $rose(fl_erase_all_o) |-> $past(wipe_volatile_o);
    endproperty
    property p_clear;
        sts_rd_i && ready_flag_o && !cmd_wr_i |=>
            !programming_error_flag_o && !lock_error_flag_o;
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready stayed high after a command write");
    a_done: assert property (p_done)
        else $error("command never completed");
    a_key: assert property (p_key)
        else $error("bad key not refused");
    a_busy_wr: assert property (p_busy_wr)
        else $error("write while busy not flagged");
    a_start: assert property (p_start)
        else $error("command started without an idle bus cycle");
    a_stall: assert property (p_stall)
        else $error("stall while ready");
    a_irq_rdy: assert property (p_irq_rdy)
        else $error("no completion interrupt");
    a_qpr: assert property (p_qpr)
        else $error("quick page read raised an interrupt");
    a_lock_irq: assert property (p_lock_irq)
        else $error("no lock error interrupt");
    a_wipe: assert property (p_wipe)
        else $error("erase all without prior volatile wipe");
    a_clear: assert property (p_clear)
        else $error("status read did not clear error flags");
endmodule // flash_sequencer_checker
bind flash_command_sequencer flash_sequencer_checker chk_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .cmd_wr_i(cmd_wr_i),
    .cmd_wdata_i(cmd_wdata_i), .rdy_ie_i(rdy_ie_i), .lock_ie_i(lock_ie_i),
    .sts_rd_i(sts_rd_i), .hsb_idle_i(hsb_idle_i),
    .ready_flag_o(ready_flag_o),
    .programming_error_flag_o(programming_error_flag_o),
    .lock_error_flag_o(lock_error_flag_o), .irq_o(irq_o),
    .hsb_stall_o(hsb_stall_o), .fl_erase_all_o(fl_erase_all_o),
    .wipe_volatile_o(wipe_volatile_o));

// ### hsb_master_model.sv
// high speed bus master model: read bursts broken by idle cycles
`timescale 1ns/1ps
module hsb_master_model #(
    parameter BURST = 3
) (
    input  wire mclk_i,
    input  wire rst_i,
    input  wire stall_i,
    output reg  hsb_idle_o
);
    reg [7:0] beat_reg;
    // a stalled beat holds the bus; a burst never runs on without an idle
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            beat_reg <= 8'h00;
            hsb_idle_o <= 1'b1;
        end else if (hsb_idle_o) begin
            beat_reg <= 8'h00;
            hsb_idle_o <= 1'b0;
        end else if (!stall_i) begin
            beat_reg <= beat_reg + 8'h01;
            hsb_idle_o <= (beat_reg == BURST - 1);
        end
    end
endmodule // hsb_master_model
